// >>> shared/tcs_pkg.sv
package tcs_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CLKSEL = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_COUNT = 4'h8;
    localparam logic [3:0] ADDR_PERIOD = 4'hc;
    localparam logic [3:0] CLKSEL_RESET = 4'h0;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Clock select codes
    // ****************************************
    localparam logic [3:0] CS_PIN = 4'h0;
    localparam logic [3:0] CS_FOSC4 = 4'h1;
    localparam logic [3:0] CS_FOSC = 4'h2;
    localparam logic [3:0] CS_HFOSC = 4'h3;
    localparam logic [3:0] CS_LFOSC = 4'h4;
    localparam logic [3:0] CS_MF500 = 4'h5;
    localparam logic [3:0] CS_MF31 = 4'h6;
    localparam logic [3:0] CS_SEC_OSC = 4'h7;
    localparam logic [3:0] CS_REFCLK = 4'h8;
    localparam logic [3:0] CS_NCO = 4'h9;
    localparam logic [3:0] CS_ZCD = 4'ha;
    localparam logic [3:0] CS_LC1 = 4'hb;
    localparam logic [3:0] CS_LC2 = 4'hc;
    localparam logic [3:0] CS_LC3 = 4'hd;
    localparam logic [3:0] CS_LC4 = 4'he;
    localparam logic [3:0] CS_RSVD = 4'hf;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    typedef struct packed {
        logic high_freq_internal_osc;
        logic mid_freq_internal_osc_500k;
        logic mid_freq_internal_osc_31k;
        logic low_freq_internal_osc;
        logic secondary_osc;
        logic reference_clock_out;
        logic numeric_osc_output;
        logic zero_cross_output;
        logic logic_cell_4_output;
        logic logic_cell_3_output;
        logic logic_cell_2_output;
        logic logic_cell_1_output;
        logic ext_clock_pin_route;
    } tcs_src_s;

    typedef struct packed {
        logic high_freq_internal_osc;
        logic mid_freq_internal_osc;
        logic low_freq_internal_osc;
    } tcs_osc_req_s;
endpackage

// >>> verilog/tcs_timer.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module tcs_timer (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire tcs_pkg::tcs_src_s src_i,
    input wire logic sleep_i,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output tcs_pkg::tcs_osc_req_s osc_keep_o,
    output logic [7:0] count_value_o
);
    // ****************************************
    // Registers
    // ****************************************
    logic [3:0] clk_sel;
    logic timer_on;
    logic prescaler_sync_select;
    logic [7:0] count_value;
    logic [7:0] period_value;
    tcs_pkg::tcs_src_s src_m;
    tcs_pkg::tcs_src_s src_s;
    logic sleep_m;
    logic sleep_s;
    logic sel_clk;
    logic sel_clk_d;
    logic [1:0] div4;
    logic tick;
    logic hold;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // Sources and sleep come from other domains
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            src_m <= '0;
            src_s <= '0;
            sleep_m <= 1'b0;
            sleep_s <= 1'b0;
        end else begin
            src_m <= src_i;
            src_s <= src_m;
            sleep_m <= sleep_i;
            sleep_s <= sleep_m;
        end
    end

    // ****************************************
    // Clock source selection
    // ****************************************
    always_comb begin
        case (clk_sel)
            tcs_pkg::CS_LC4: sel_clk = src_s.logic_cell_4_output;
            tcs_pkg::CS_LC3: sel_clk = src_s.logic_cell_3_output;
            tcs_pkg::CS_LC2: sel_clk = src_s.logic_cell_2_output;
            tcs_pkg::CS_LC1: sel_clk = src_s.logic_cell_1_output;
            tcs_pkg::CS_ZCD: sel_clk = src_s.zero_cross_output;
            tcs_pkg::CS_NCO: sel_clk = src_s.numeric_osc_output;
            tcs_pkg::CS_REFCLK: sel_clk = src_s.reference_clock_out;
            tcs_pkg::CS_SEC_OSC: sel_clk = src_s.secondary_osc;
            tcs_pkg::CS_MF31: sel_clk = src_s.mid_freq_internal_osc_31k;
            tcs_pkg::CS_MF500: sel_clk = src_s.mid_freq_internal_osc_500k;
            tcs_pkg::CS_LFOSC: sel_clk = src_s.low_freq_internal_osc;
            tcs_pkg::CS_HFOSC: sel_clk = src_s.high_freq_internal_osc;
            tcs_pkg::CS_FOSC: sel_clk = 1'b1;
            tcs_pkg::CS_FOSC4: sel_clk = (div4 == tcs_pkg::DIV4_LAST);
            tcs_pkg::CS_PIN: sel_clk = src_s.ext_clock_pin_route;
            default: sel_clk = 1'b0; // Reserved code never ticks
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            div4 <= '0;
            sel_clk_d <= 1'b0;
        end else begin
            div4 <= div4 + 2'h1;
            sel_clk_d <= sel_clk;
        end
    end

    // System clock itself ticks every cycle, system clock/4 on its div4 pulse; others on a rising edge
    assign tick = (clk_sel == tcs_pkg::CS_FOSC) ? 1'b1
                : (clk_sel == tcs_pkg::CS_FOSC4) ? sel_clk
                : (sel_clk & ~sel_clk_d);
    assign hold = sleep_s & prescaler_sync_select;

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !timer_on) begin
            count_value <= '0;
        end else if (do_write && aw_addr == tcs_pkg::ADDR_COUNT
                     && w_strb[0]) begin
            count_value <= w_data[7:0];
        end else if (tick && !hold) begin
            count_value <= (count_value == period_value) ? 8'h00
                         : count_value + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            osc_keep_o <= '0;
            count_value_o <= '0;
        end else begin
            // Keep only the oscillator that is clocking the timer
            osc_keep_o.high_freq_internal_osc <= timer_on
                && clk_sel == tcs_pkg::CS_HFOSC;
            osc_keep_o.mid_freq_internal_osc <= timer_on
                && (clk_sel == tcs_pkg::CS_MF31
                    || clk_sel == tcs_pkg::CS_MF500);
            osc_keep_o.low_freq_internal_osc <= timer_on
                && clk_sel == tcs_pkg::CS_LFOSC;
            count_value_o <= count_value;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= tcs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr[1:0] == 2'h0)
                    ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            clk_sel <= tcs_pkg::CLKSEL_RESET;
            timer_on <= 1'b0;
            prescaler_sync_select <= 1'b0;
            period_value <= tcs_pkg::PERIOD_RESET;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                tcs_pkg::ADDR_CLKSEL: clk_sel <= w_data[3:0];
                tcs_pkg::ADDR_CTRL: begin
                    timer_on <= w_data[tcs_pkg::CTRL_ON_BIT];
                    prescaler_sync_select <= w_data[tcs_pkg::CTRL_SYNC_BIT];
                end
                tcs_pkg::ADDR_PERIOD: begin
                    if (!hold) begin
                        period_value <= w_data[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= tcs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= tcs_pkg::RESP_OKAY;
            case (s_axi_araddr_i)
                tcs_pkg::ADDR_CLKSEL: s_axi_rdata_o <= {28'h0, clk_sel};
                tcs_pkg::ADDR_CTRL: s_axi_rdata_o <=
                    {30'h0, prescaler_sync_select, timer_on};
                tcs_pkg::ADDR_COUNT: s_axi_rdata_o <= {24'h0, count_value};
                tcs_pkg::ADDR_PERIOD: s_axi_rdata_o <= {24'h0, period_value};
                default: begin
                    s_axi_rdata_o <= '0;
                    s_axi_rresp_o <= tcs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_sleep_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (hold && timer_on && $past(hold) && $past(timer_on)
         && !$past(do_write)) |-> $stable(count_value);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("count moved while held in sleep");

    property p_period_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $past(hold) |-> $stable(period_value);
    endproperty
    a_period_hold: assert property (p_period_hold)
        else $error("period changed in sleep");

    property p_fosc_counts;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (timer_on && !hold && clk_sel == tcs_pkg::CS_FOSC && !do_write
         && count_value != period_value) ##1 timer_on
        |-> count_value == $past(count_value) + 8'h01;
    endproperty
    a_fosc_counts: assert property (p_fosc_counts)
        else $error("system clock source did not count");

    property p_osc_keep;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (timer_on && clk_sel == tcs_pkg::CS_LFOSC)
        |=> osc_keep_o.low_freq_internal_osc;
    endproperty
    a_osc_keep: assert property (p_osc_keep)
        else $error("low oscillator not kept");

    property p_rsvd_still;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (clk_sel == tcs_pkg::CS_RSVD && !do_write && timer_on)
        ##1 timer_on |-> $stable(count_value);
    endproperty
    a_rsvd_still: assert property (p_rsvd_still)
        else $error("reserved source ticked");

    property p_upper_zero;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (s_axi_rvalid_o && $rose(s_axi_rvalid_o)
         && $past(s_axi_araddr_i) == tcs_pkg::ADDR_CLKSEL)
        |-> s_axi_rdata_o[31:4] == 28'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper select bits not zero");

    property p_off_clear;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !timer_on |=> count_value == 8'h00;
    endproperty
    a_off_clear: assert property (p_off_clear)
        else $error("counter not cleared while off");

    property p_reset_sel;
        @(posedge clk_sys_i) !reset_n_i |=> clk_sel == tcs_pkg::CS_PIN;
    endproperty
    a_reset_sel: assert property (p_reset_sel)
        else $error("select not zero after reset");
endmodule

// >>> tb/tcs_src_model.sv
`timescale 1ns/1ps
// ****************************************
// Clock source model
// ****************************************
// Each source toggles on a shared beat while its run bit is set; a
// stopped source holds its last level, as a gated oscillator would.
module tcs_src_model #(
    parameter int HALF = 2
) (
    input wire logic clk_i,
    input wire logic [12:0] run_i,
    output tcs_pkg::tcs_src_s src_o
);
    int cnt = 0;
    logic [12:0] lvl = 13'h0;

    always_ff @(posedge clk_i) begin
        if (cnt == HALF - 1) begin
            cnt <= 0;
            lvl <= lvl ^ run_i;
        end else begin
            cnt <= cnt + 1;
        end
    end

    assign src_o = tcs_pkg::tcs_src_s'(lvl);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Register tests for the timer clock select
// ****************************************
module tb_top;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [12:0] run = 13'h1fff;
    tcs_pkg::tcs_src_s src;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs, br;
    logic [31:0] rdata, rd;
    tcs_pkg::tcs_osc_req_s osc_keep;
    logic [7:0] count_value, snap;
    int n_fail = 0;
    int cmp_count = 0;

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    tcs_src_model #(.HALF(2)) src_model (.clk_i(clk_sys_i), .run_i(run),
        .src_o(src));

    tcs_timer dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .src_i(src), .sleep_i(sleep_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .osc_keep_o(osc_keep), .count_value_o(count_value));

    task give_verdict;
        $display("Errors: %0d, comparisons: %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One source per select code except 1, 2 and 15, straight from the code table
    function automatic logic [12:0] src_mask(input int c);
        tcs_pkg::tcs_src_s m;
        m = '0;
        case (c)
            0: m.ext_clock_pin_route = 1'b1;
            3: m.high_freq_internal_osc = 1'b1;
            4: m.low_freq_internal_osc = 1'b1;
            5: m.mid_freq_internal_osc_500k = 1'b1;
            6: m.mid_freq_internal_osc_31k = 1'b1;
            7: m.secondary_osc = 1'b1;
            8: m.reference_clock_out = 1'b1;
            9: m.numeric_osc_output = 1'b1;
            10: m.zero_cross_output = 1'b1;
            11: m.logic_cell_1_output = 1'b1;
            12: m.logic_cell_2_output = 1'b1;
            13: m.logic_cell_3_output = 1'b1;
            14: m.logic_cell_4_output = 1'b1;
            default: m = '0;
        endcase
        return m;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task timeout_chk(input int n);
        if (n >= 50) begin
            n_fail++;
            $display("Error at %0t: bus timeout", $time);
            give_verdict();
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        br = bresp;
        bready <= 1'b0;
        timeout_chk(n);
    endtask

    task rd_reg(input logic [3:0] a, output logic [31:0] d,
                output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        timeout_chk(n);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_reg(tcs_pkg::ADDR_CLKSEL, rd, rs);
        chk(rd, 32'h0);
        rd_reg(tcs_pkg::ADDR_PERIOD, rd, rs);
        chk(rd, 32'hff);
        wr(tcs_pkg::ADDR_CLKSEL, 32'hff);
        chk({30'h0, br}, {30'h0, tcs_pkg::RESP_OKAY});
        rd_reg(tcs_pkg::ADDR_CLKSEL, rd, rs);
        chk(rd, 32'hf);
        rd_reg(4'h6, rd, rs);
        chk({30'h0, rs}, {30'h0, tcs_pkg::RESP_SLVERR});
        wr(4'h2, 32'h0);
        chk({30'h0, br}, {30'h0, tcs_pkg::RESP_SLVERR});
        // Every code: a tick must reach the counter unless reserved
        for (int c = 0; c < 16; c++) begin
            wr(tcs_pkg::ADDR_CTRL, 32'h0);
            wr(tcs_pkg::ADDR_CLKSEL, 32'(c));
            // All but the selected source run: only system clock codes count
            run <= ~src_mask(c);
            wr(tcs_pkg::ADDR_CTRL, 32'h1);
            repeat (40) @(posedge clk_sys_i);
            rd_reg(tcs_pkg::ADDR_COUNT, rd, rs);
            chk({31'h0, rd[7:0] != 8'h0},
                {31'h0, c == 1 || c == 2});
            // Only the selected source runs: every code but reserved counts
            run <= src_mask(c);
            repeat (40) @(posedge clk_sys_i);
            rd_reg(tcs_pkg::ADDR_COUNT, rd, rs);
            chk({31'h0, rd[7:0] != 8'h0}, {31'h0, c != 15});
            chk({29'h0, osc_keep}, {29'h0, c == 3, c == 5 || c == 6,
                c == 4});
            wr(tcs_pkg::ADDR_CTRL, 32'h0);
            rd_reg(tcs_pkg::ADDR_COUNT, rd, rs);
            chk(rd, 32'h0);
        end
        // Sleep with sync: count and period frozen
        wr(tcs_pkg::ADDR_CLKSEL, {28'h0, tcs_pkg::CS_FOSC});
        wr(tcs_pkg::ADDR_CTRL, 32'h3);
        sleep_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        snap = count_value;
        wr(tcs_pkg::ADDR_PERIOD, 32'h10);
        repeat (20) @(posedge clk_sys_i);
        chk({24'h0, count_value}, {24'h0, snap});
        rd_reg(tcs_pkg::ADDR_PERIOD, rd, rs);
        chk(rd, 32'hff);
        rd_reg(tcs_pkg::ADDR_COUNT, rd, rs);
        chk(rd, {24'h0, snap});
        // Sleep without sync: counts only while the source runs
        wr(tcs_pkg::ADDR_CTRL, 32'h1);
        snap = count_value;
        repeat (20) @(posedge clk_sys_i);
        chk({31'h0, count_value != snap}, 32'h1);
        run <= 13'h0;
        wr(tcs_pkg::ADDR_CLKSEL, {28'h0, tcs_pkg::CS_PIN});
        repeat (5) @(posedge clk_sys_i);
        snap = count_value;
        repeat (20) @(posedge clk_sys_i);
        chk({24'h0, count_value}, {24'h0, snap});
        give_verdict();
    end
endmodule
